//--- bench/host_side_model.sv
// Host-side model: strap pull choice and resolved hold pin level
`timescale 1ns/100ps
module host_side_model (
    input  wire logic ref_clk,
    input  wire logic pull_up,
    input  wire logic hold_level,
    input  wire logic hold_oe,
    output logic      polarity_strap,
    output logic      pin_level
);
    logic last_level;

    initial last_level = 1'b0;

    // strap pull level
    // A fitted pull-up reads high; otherwise the internal pull-down wins
    assign polarity_strap = pull_up;

    // No pull on the pin: a released pin shows the inverse of the last driven level
    assign pin_level = hold_oe ? hold_level : ~last_level;

    always @(posedge ref_clk) begin
        if (hold_oe) begin
            last_level <= hold_level;
        end
    end
endmodule

//--- bench/host_wait_polarity_reset_tb.sv
// Self-checking bench for the host cycle hold output block
`timescale 1ns/100ps
module host_wait_polarity_reset_tb;
    logic                 ref_clk;
    logic                 rst_n;
    logic                 pull_up;
    logic                 float_strap;
    logic                 access_start;
    logic                 access_ready;
    logic                 polarity_strap;
    logic                 hold_level;
    logic                 hold_oe;
    logic                 busy;
    logic                 pin_level;
    hold_pkg::host_mode_e host_mode;
    int                   n_errors;
    int                   comparisons;

    initial ref_clk = 1'b0;
    always #2 ref_clk = ~ref_clk;

    host_wait_polarity_reset host_wait_polarity_reset_inst (
        .ref_clk        (ref_clk),
        .rst_n          (rst_n),
        .polarity_strap (polarity_strap),
        .float_strap    (float_strap),
        .host_mode      (host_mode),
        .access_start   (access_start),
        .access_ready   (access_ready),
        .hold_level     (hold_level),
        .hold_oe        (hold_oe),
        .busy           (busy)
    );

    host_side_model host_side_model_inst (
        .ref_clk        (ref_clk),
        .pull_up        (pull_up),
        .hold_level     (hold_level),
        .hold_oe        (hold_oe),
        .polarity_strap (polarity_strap),
        .pin_level      (pin_level)
    );

    task automatic chk(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Straps change together with reset entry; every reset after the first is also a mid-run reset
    task automatic reset_case(input logic pol, input logic flt);
        // Mid-run resets land on an open access so the tracker has state to clear
        if (rst_n) begin
            access_start = 1'b1;
            @(negedge ref_clk);
            access_start = 1'b0;
            chk("busy before reset", 1'b1, busy);
        end
        @(negedge ref_clk);
        rst_n = 1'b0;
        pull_up = pol;
        float_strap = flt;
        access_start = 1'b0;
        access_ready = 1'b0;
        repeat (12) begin
            @(negedge ref_clk);
            chk("busy in reset", 1'b0, busy);
            chk("enable in reset", ~flt, hold_oe);
            if (!flt) chk("level in reset", ~pol, hold_level);
        end
        rst_n = 1'b1;
        @(negedge ref_clk);
        chk("enable after reset", 1'b1, hold_oe);
        chk("idle level", ~pol, pin_level);
        // Strap moves after release; the latched polarity must not follow it
        pull_up = ~pol;
        $display("reset case pol=%b float=%b done", pol, flt);
    endtask

    // One access held for three cycles before the ready is given
    task automatic access_case(input hold_pkg::host_mode_e mode, input logic pol);
        logic is_wait;
        is_wait = (mode <= hold_pkg::MODE_ISA);
        host_mode = mode;
        access_start = 1'b1;
        @(negedge ref_clk);
        access_start = 1'b0;
        chk("busy on start", 1'b1, busy);
        repeat (3) begin
            @(negedge ref_clk);
            chk("level while held", is_wait ? pol : ~pol, pin_level);
        end
        access_ready = 1'b1;
        @(negedge ref_clk);
        access_ready = 1'b0;
        chk("busy after ready", ~is_wait, busy);
        chk("level after ready", is_wait ? pol : ~pol, pin_level);
        @(negedge ref_clk);
        chk("level next", is_wait ? ~pol : pol, pin_level);
        chk("busy released", 1'b0, busy);
        @(negedge ref_clk);
        chk("level final", ~pol, pin_level);
        $display("access case mode=%0d done", mode);
    endtask

    initial begin
        rst_n = 1'b0;
        pull_up = 1'b0;
        float_strap = 1'b0;
        access_start = 1'b0;
        access_ready = 1'b0;
        host_mode = hold_pkg::MODE_GENERIC;
        for (int i = 0; i < 4; i++) begin
            reset_case(i[0], i[1]);
            for (int m = 0; m < 7; m++) begin
                if ((m > 2) == i[0]) access_case(hold_pkg::host_mode_e'(m), i[0]);
            end
        end
        conclude();
    end

    // About 150 cycles are needed; the limit leaves ample margin
    initial begin
        #20000;
        n_errors++;
        $display("watchdog expired");
        conclude();
    end
endmodule

//--- hw/hold_consts.svh
// Constants for the host cycle hold output block
`ifndef HOLD_CONSTS_SVH
`define HOLD_CONSTS_SVH
`define HOLD_LAT_CYCLES 4'h2
`define HOLD_LAT_W      4
`define HOLD_TS_RESET   1'b0
`endif

//--- hw/hold_if.sv
// Carrier between the access tracker and the pin driver
`timescale 1ns/100ps
interface hold_if;
    logic asserted;
    logic active_high;
    logic tristate_ok;
    modport src (output asserted, output active_high, output tristate_ok);
    modport dst (input asserted, input active_high, input tristate_ok);
endinterface

//--- hw/hold_pin_drv.sv
// Pin driver applying the latched polarity to the hold output
`timescale 1ns/100ps
`include "hold_consts.svh"
module hold_pin_drv (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    hold_if.dst       hif,
    output logic      hold_level,
    output logic      hold_oe
);
    logic o_reg;
    logic o_next;
    logic oe_reg;
    logic oe_next;

    always_comb begin
        if (!rst_n) begin
            o_next  = !hif.active_high;
            oe_next = !hif.tristate_ok;
        end else begin
            o_next  = hif.asserted ~^ hif.active_high;
            oe_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        o_reg  <= o_next;
        oe_reg <= oe_next;
    end

    assign hold_level = o_reg;
    assign hold_oe    = oe_reg;
endmodule

//--- hw/hold_pkg.sv
// Types for the host cycle hold output block
package hold_pkg;
    typedef enum logic [2:0] {
        MODE_GENERIC,
        MODE_PCCARD,
        MODE_ISA,
        MODE_ASYNC_ACK,
        MODE_SIZED_ACK,
        MODE_SYNC_READY,
        MODE_SYNC_TA
    } host_mode_e;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HOLD,
        ST_DONE
    } hold_state_e;
endpackage

//--- hw/host_wait_polarity_reset.sv
// Host cycle hold output with strapped polarity and reset behaviour
// Overview of operation
// - Strap latched at reset release sets polarity
// - Generic and card modes: wait stretches access
// - ISA mode: output is channel ready
// - Async acknowledge mode: acknowledge ends cycle
// - Sync ready mode: ready completes access
// - Sync acknowledge mode: acknowledge ends transaction
// - Reset with float strap: output high impedance
// - Reset, driven active low: drive 1
// - Reset, driven active high: drive 0
// - Reset clears the tracker state and loads the straps, outputs go inactive
`timescale 1ns/100ps
`include "hold_consts.svh"
module host_wait_polarity_reset #(
    parameter int LAT_W = `HOLD_LAT_W
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             polarity_strap,
    input  wire logic             float_strap,
    input  wire hold_pkg::host_mode_e host_mode,
    input  wire logic             access_start,
    input  wire logic             access_ready,
    output logic                  hold_level,
    output logic                  hold_oe,
    output logic                  busy
);
    hold_if hif ();

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    logic pol_reg;
    logic pol_next;
    logic ts_reg;
    logic ts_next;

    // sample while reset held
    // The last sample before release is the rising-edge value.
    always_comb begin
        pol_next = pol_reg;
        ts_next  = ts_reg;
        if (!rst_n) begin
            pol_next = polarity_strap;
            ts_next  = float_strap;
        end
    end

    always_ff @(posedge ref_clk) begin
        pol_reg      <= pol_next;
        ts_reg       <= ts_next;
    end

    // ----------------------------------------------------------------
    // Access tracker
    // ----------------------------------------------------------------
    hold_pkg::hold_state_e st_reg;
    hold_pkg::hold_state_e st_next;

    function automatic logic is_reply_mode(input hold_pkg::host_mode_e m);
        // Acknowledge and sync ready flavours pulse on completion rather than stretch
        case (m)
            hold_pkg::MODE_ASYNC_ACK,
            hold_pkg::MODE_SIZED_ACK,
            hold_pkg::MODE_SYNC_READY,
            hold_pkg::MODE_SYNC_TA: is_reply_mode = 1'b1;
            default:                is_reply_mode = 1'b0;
        endcase
    endfunction

    always_comb begin
        st_next = st_reg;
        if (!rst_n) begin
            st_next = hold_pkg::ST_IDLE;
        end else begin
            case (st_reg)
                hold_pkg::ST_IDLE: begin
                    if (access_start) begin
                        st_next = hold_pkg::ST_HOLD;
                    end
                end
                hold_pkg::ST_HOLD: begin
                    if (access_ready) begin
                        st_next = is_reply_mode(host_mode) ? hold_pkg::ST_DONE : hold_pkg::ST_IDLE;
                    end
                end
                hold_pkg::ST_DONE: begin
                    st_next = hold_pkg::ST_IDLE;
                end
                default: begin
                    st_next = hold_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        st_reg <= st_next;
    end

    // ----------------------------------------------------------------
    // Mode mapping of the hold output meaning
    // ----------------------------------------------------------------
    logic asserted;

    always_comb begin
        case (host_mode)
            hold_pkg::MODE_GENERIC,
            hold_pkg::MODE_PCCARD:     asserted = (st_reg == hold_pkg::ST_HOLD);
            hold_pkg::MODE_ISA:        asserted = (st_reg == hold_pkg::ST_HOLD);
            hold_pkg::MODE_ASYNC_ACK:  asserted = (st_reg == hold_pkg::ST_DONE);
            hold_pkg::MODE_SIZED_ACK:  asserted = (st_reg == hold_pkg::ST_DONE);
            hold_pkg::MODE_SYNC_READY: asserted = (st_reg == hold_pkg::ST_DONE);
            hold_pkg::MODE_SYNC_TA:    asserted = (st_reg == hold_pkg::ST_DONE);
            default:                   asserted = 1'b0;
        endcase
    end

    assign hif.asserted    = asserted;
    // Next values let the pin follow the straps from the first reset edge; outside reset they equal the latch
    assign hif.active_high = pol_next;
    assign hif.tristate_ok = ts_next;
    assign busy            = (st_reg != hold_pkg::ST_IDLE);

    hold_pin_drv hold_pin_drv_inst (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .hif        (hif),
        .hold_level (hold_level),
        .hold_oe    (hold_oe)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_hold_then_ready;
        (st_reg == hold_pkg::ST_HOLD) && access_ready && is_reply_mode(host_mode);
    endsequence

    property p_reset_level;
        @(posedge ref_clk) !rst_n |=> (hold_level == !$past(polarity_strap));
    endproperty
    a_reset_level: assert property (p_reset_level) else $error("hold level wrong in reset");

    property p_reset_float;
        @(posedge ref_clk) (!rst_n && float_strap) |=> !hold_oe;
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("hold driven in float reset");

    property p_reset_drive;
        @(posedge ref_clk) (!rst_n && !float_strap) |=> hold_oe;
    endproperty
    a_reset_drive: assert property (p_reset_drive) else $error("hold not driven in reset");

    property p_pol_latch;
        @(posedge ref_clk) disable iff (!rst_n) $rose(rst_n) |-> (pol_reg == $past(polarity_strap));
    endproperty
    a_pol_latch: assert property (p_pol_latch) else $error("strap not latched");

    property p_pol_stable;
        @(posedge ref_clk) disable iff (!rst_n) rst_n && $past(rst_n) |-> $stable(pol_reg);
    endproperty
    a_pol_stable: assert property (p_pol_stable) else $error("polarity changed outside reset");

    property p_clear;
        @(posedge ref_clk) !rst_n |=> !busy;
    endproperty
    a_clear: assert property (p_clear) else $error("state not cleared");

    property p_hold_pin;
        @(posedge ref_clk) disable iff (!rst_n)
            (st_reg == hold_pkg::ST_HOLD) && !is_reply_mode(host_mode) ##1 rst_n
            |-> (hold_level == pol_reg) && hold_oe;
    endproperty
    a_hold_pin: assert property (p_hold_pin) else $error("wait not asserted");

    property p_reply_pulse;
        @(posedge ref_clk) disable iff (!rst_n)
            s_hold_then_ready |=> (st_reg == hold_pkg::ST_DONE) ##1 (st_reg == hold_pkg::ST_IDLE);
    endproperty
    a_reply_pulse: assert property (p_reply_pulse) else $error("reply not one cycle");

    property p_hold_until_ready;
        @(posedge ref_clk) disable iff (!rst_n)
            (st_reg == hold_pkg::ST_HOLD) && !access_ready |=> (st_reg == hold_pkg::ST_HOLD);
    endproperty
    a_hold_until_ready: assert property (p_hold_until_ready) else $error("hold dropped early");

    sequence s_wait_ready;
        (st_reg == hold_pkg::ST_HOLD) && access_ready && !is_reply_mode(host_mode);
    endsequence

    sequence s_idle_then_released;
        (st_reg == hold_pkg::ST_IDLE) ##1 (hold_level != pol_reg);
    endsequence

    // Reply pulse: one cycle at the active level, then back to inactive
    sequence s_reply_seen;
        ##1 ((hold_level == pol_reg) && hold_oe) ##1 (hold_level != pol_reg);
    endsequence

    property p_wait_release;
        @(posedge ref_clk) disable iff (!rst_n)
            s_wait_ready |=> s_idle_then_released;
    endproperty
    a_wait_release: assert property (p_wait_release) else $error("wait not released after ready");

    property p_start_hold;
        @(posedge ref_clk) disable iff (!rst_n)
            (st_reg == hold_pkg::ST_IDLE) && access_start |=> (st_reg == hold_pkg::ST_HOLD);
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("access start not taken");

    property p_reply_level;
        @(posedge ref_clk) disable iff (!rst_n)
            (st_reg == hold_pkg::ST_DONE) |=> (hold_level == pol_reg) && hold_oe;
    endproperty
    a_reply_level: assert property (p_reply_level) else $error("acknowledge not shown");

    property p_sized_ack;
        @(posedge ref_clk) disable iff (!rst_n)
            (st_reg == hold_pkg::ST_HOLD) && access_ready && (host_mode == hold_pkg::MODE_SIZED_ACK)
            |=> s_reply_seen;
    endproperty
    a_sized_ack: assert property (p_sized_ack) else $error("size acknowledge not pulsed");

    property p_sync_ready;
        @(posedge ref_clk) disable iff (!rst_n)
            (st_reg == hold_pkg::ST_HOLD) && access_ready && (host_mode == hold_pkg::MODE_SYNC_READY)
            |=> s_reply_seen;
    endproperty
    a_sync_ready: assert property (p_sync_ready) else $error("ready reply not pulsed");

    property p_idle_level;
        @(posedge ref_clk) disable iff (!rst_n)
            (st_reg == hold_pkg::ST_IDLE) |=> (hold_level != pol_reg) && hold_oe;
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("hold not inactive while idle");
endmodule
